// ### inc/i2c_seg_pkg.sv
// constants shared by the two-wire segment engine and its timing helpers
package i2c_seg_pkg;
    localparam int CLK_MHZ = 250;
    localparam int REF_MHZ = 24;
    localparam logic [1:0] MODE_I2C = 2'h3;
    localparam logic [3:0] SEG_BITS = 4'h9;
    localparam logic [3:0] DATA_BITS = 4'h8;
    // register byte offsets
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_CTRL1 = 8'h08;
    localparam logic [7:0] ADDR_CTRL2 = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_LIN = 8'h14;
    localparam logic [7:0] ADDR_EXP = 8'h18;
    localparam logic [7:0] ADDR_EVFLAG = 8'h1c;
    localparam logic [7:0] ADDR_EVMASK = 8'h20;
    localparam logic [7:0] ADDR_TOPEN = 8'h24;
    // segment_control_reg bits
    localparam int CMD_START = 0;
    localparam int CMD_SEND = 1;
    localparam int CMD_RECV = 2;
    localparam int CMD_STOP = 3;
    // segment_status_reg bits
    localparam int ST_RXNAK = 0;
    localparam int ST_TXFIN = 1;
    localparam int ST_RXFIN = 2;
    localparam int ST_CMDFIN = 3;
    // event flag bits
    localparam int EV_CMD = 0;
    localparam int EV_NACK = 1;
    localparam int EV_TX = 2;
    localparam int EV_RX = 3;
    localparam int EV_OVR = 4;
    localparam int EV_UND = 5;
    localparam int EV_W = 6;
    // reset values
    localparam logic [3:0] RATE_LIN_RST = 4'h0;
    localparam logic [3:0] RATE_EXP_RST = 4'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
endpackage : i2c_seg_pkg

// ### hdl/ref_tick_gen.sv
// fractional divider giving a 24 MHz reference enable from the system clock
`timescale 1ns/1ns
module ref_tick_gen #(
    parameter int CLK_MHZ_P = i2c_seg_pkg::CLK_MHZ,
    parameter int REF_MHZ_P = i2c_seg_pkg::REF_MHZ
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    import i2c_seg_pkg::*;
    typedef struct packed {
        logic [8:0] acc;
        logic tick;
    } ref_state_t;
    ref_state_t q, d;
    logic [8:0] sum;

    always_comb begin
        d = q;
        sum = q.acc + 9'(REF_MHZ_P);
        d.tick = 1'b0;
        if (sum >= 9'(CLK_MHZ_P)) begin
            d.acc = sum - 9'(CLK_MHZ_P);
            d.tick = 1'b1;
        end else begin
            d.acc = sum;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
endmodule : ref_tick_gen

// ### hdl/half_period_timer.sv
// counts (lin+1)*2^exp reference ticks per half bus period
`timescale 1ns/1ns
module half_period_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_tick_i,
    input wire logic run_i,
    input wire logic [3:0] lin_i,
    input wire logic [3:0] exp_i,
    output logic tick_o
);
    import i2c_seg_pkg::*;
    typedef struct packed {
        logic [19:0] cnt;
        logic tick;
    } half_state_t;
    half_state_t q, d;
    logic [19:0] target;

    always_comb begin
        d = q;
        target = ({16'h0000, lin_i} + 20'h00001) << exp_i;
        d.tick = 1'b0;
        if (!run_i) begin
            d.cnt = '0;
        end else if (ref_tick_i) begin
            if (q.cnt + 20'h00001 >= target) begin
                d.cnt = '0;
                d.tick = 1'b1;
            end else begin
                d.cnt = q.cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
endmodule : half_period_timer

// ### hdl/i2c_master_segment_engine.sv
// software-driven two-wire bus master with one-byte buffers and wishbone registers
`timescale 1ns/1ns
// Notes on behaviour
// - bus master only when mode field equals 3
// - start bit makes start or repeated start
// - send bit shifts out byte, samples ack
// - receive bit clocks in byte, returns ack
// - stop bit makes a stop condition
// - no command bit set keeps engine idle
// - one-byte buffers, software access only
// - start/stop bit self-clears, sets command-done
// - send clears itself, sets transmit-done flag
// - receive clears itself, sets receive-done flag
// - send or receive end records the ninth-bit ack or nack seen on sda
// - ack-select bit picks receive ack or nack
// - event on command-done rising
// - event on transmitted byte answered nack
// - event on transmit-done rising
// - event on receive-done rising
// - overrun event, arriving byte dropped when full
// - underrun event when sending from empty buffer
// - event reaches irq only with both masks
// - bit rate 24MHz/(2*(lin+1)*2^exp)
module i2c_master_segment_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic irq_o
);
    import i2c_seg_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_START_A, ST_START_B, ST_START_C,
        ST_BIT_LO, ST_BIT_HI, ST_STOP_A, ST_STOP_B
    } seg_state_t;

    typedef struct packed {
        seg_state_t st;
        logic [1:0] mode;
        logic [3:0] cmd;
        logic ack_sel;
        logic [3:0] lin;
        logic [3:0] exp;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] rx_buf;
        logic rx_full;
        logic [7:0] shift;
        logic [3:0] nbit;
        logic [3:0] stat;
        logic [EV_W-1:0] ev_flag;
        logic [EV_W-1:0] ev_mask;
        logic top_en;
        logic scl_rel;
        logic sda_rel;
        logic sda_pend;
        logic sda_next;
        logic pin_lo;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic irq;
    } eng_state_t;

    eng_state_t q, d;
    logic ref_tick;
    logic half_tick;
    logic run;
    logic access;
    logic wr;
    logic launch;
    logic seg_end;
    logic rd_data;

    assign run = (q.st != ST_IDLE);

    ref_tick_gen u_ref (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(ref_tick)
    );

    // bus clock divider from the 24 MHz reference
    half_period_timer u_half (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_tick_i(ref_tick),
        .run_i(run),
        .lin_i(q.lin),
        .exp_i(q.exp),
        .tick_o(half_tick)
    );

    always_comb begin
        d = q;
        launch = 1'b0;
        seg_end = 1'b0;
        access = wb_cyc_i && wb_stb_i && !q.wb_ack;
        wr = wb_cyc_i && wb_stb_i && q.wb_ack && wb_we_i && wb_sel_i[0];
        rd_data = access && !wb_we_i && (wb_adr_i == ADDR_DATA);
        d.wb_ack = access;

        // register reads, unmapped offsets read as zero
        d.wb_dat = '0;
        if (access && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_MODE: d.wb_dat[1:0] = q.mode;
                ADDR_DATA: d.wb_dat[7:0] = q.rx_buf;
                ADDR_CTRL1: d.wb_dat[3:0] = q.cmd;
                ADDR_CTRL2: d.wb_dat[0] = q.ack_sel;
                ADDR_STAT: d.wb_dat[3:0] = q.stat;
                ADDR_LIN: d.wb_dat[3:0] = q.lin;
                ADDR_EXP: d.wb_dat[3:0] = q.exp;
                ADDR_EVFLAG: d.wb_dat[EV_W-1:0] = q.ev_flag;
                ADDR_EVMASK: d.wb_dat[EV_W-1:0] = q.ev_mask;
                ADDR_TOPEN: d.wb_dat[0] = q.top_en;
                default: d.wb_dat = '0;
            endcase
        end
        if (rd_data) begin
            d.rx_full = 1'b0;
        end

        if (wr) begin
            case (wb_adr_i)
                ADDR_MODE: d.mode = wb_dat_i[1:0];
                ADDR_DATA: begin
                    d.tx_buf = wb_dat_i[7:0];
                    d.tx_full = 1'b1;
                end
                ADDR_CTRL1: begin
                    // a new segment is accepted only while none is pending
                    if (q.st == ST_IDLE && q.cmd == 4'h0) begin
                        d.cmd = wb_dat_i[3:0];
                        d.stat[ST_TXFIN] = 1'b0;
                        d.stat[ST_RXFIN] = 1'b0;
                        d.stat[ST_CMDFIN] = 1'b0;
                    end
                end
                ADDR_CTRL2: d.ack_sel = wb_dat_i[0];
                ADDR_LIN: d.lin = wb_dat_i[3:0];
                ADDR_EXP: d.exp = wb_dat_i[3:0];
                ADDR_EVFLAG: d.ev_flag = q.ev_flag & ~wb_dat_i[EV_W-1:0];
                ADDR_EVMASK: d.ev_mask = wb_dat_i[EV_W-1:0];
                ADDR_TOPEN: d.top_en = wb_dat_i[0];
                default: d.pin_lo = q.pin_lo;
            endcase
        end

        // data changes one cycle after scl falls to keep hold time
        if (q.sda_pend) begin
            d.sda_rel = q.sda_next;
            d.sda_pend = 1'b0;
        end

        case (q.st)
            ST_IDLE: begin
                if (q.mode == MODE_I2C && q.cmd != 4'h0) begin
                    launch = 1'b1;
                    d.nbit = 4'h0;
                    d.sda_pend = 1'b1;
                    if (q.cmd[CMD_START]) begin
                        d.st = ST_START_A;
                        d.sda_next = 1'b1;
                    end else if (q.cmd[CMD_SEND]) begin
                        d.st = ST_BIT_LO;
                        d.shift = q.tx_buf;
                        d.sda_next = q.tx_buf[7];
                        d.tx_full = 1'b0;
                        if (!q.tx_full) begin
                            d.ev_flag[EV_UND] = 1'b1;
                        end
                    end else if (q.cmd[CMD_RECV]) begin
                        d.st = ST_BIT_LO;
                        d.shift = 8'h00;
                        d.sda_next = 1'b1;
                    end else begin
                        d.st = ST_STOP_A;
                        d.sda_next = 1'b0;
                    end
                end
            end
            ST_START_A: begin
                if (half_tick) begin
                    d.scl_rel = 1'b1;
                    d.st = ST_START_B;
                end
            end
            ST_START_B: begin
                // waits for scl to really rise, so a stretching slave holds us
                if (half_tick && scl_i) begin
                    d.sda_rel = 1'b0;
                    d.st = ST_START_C;
                end
            end
            ST_START_C: begin
                if (half_tick) begin
                    d.scl_rel = 1'b0;
                    seg_end = 1'b1;
                end
            end
            ST_BIT_LO: begin
                if (half_tick) begin
                    d.scl_rel = 1'b1;
                    d.st = ST_BIT_HI;
                end
            end
            ST_BIT_HI: begin
                if (half_tick && scl_i) begin
                    d.scl_rel = 1'b0;
                    if (q.nbit == DATA_BITS) begin
                        seg_end = 1'b1;
                    end else begin
                        d.shift = {q.shift[6:0], sda_i};
                        d.nbit = q.nbit + 4'h1;
                        d.st = ST_BIT_LO;
                        d.sda_pend = 1'b1;
                        if (q.nbit + 4'h1 == DATA_BITS) begin
                            // ninth bit: slave answers on send, we answer on receive
                            d.sda_next = q.cmd[CMD_SEND] ? 1'b1 : !q.ack_sel;
                        end else begin
                            d.sda_next = q.cmd[CMD_SEND] ? q.shift[6] : 1'b1;
                        end
                    end
                end
            end
            ST_STOP_A: begin
                if (half_tick) begin
                    d.scl_rel = 1'b1;
                    d.st = ST_STOP_B;
                end
            end
            ST_STOP_B: begin
                if (half_tick && scl_i) begin
                    d.sda_rel = 1'b1;
                    seg_end = 1'b1;
                end
            end
            default: d.st = ST_IDLE;
        endcase

        if (seg_end) begin
            d.st = ST_IDLE;
            d.cmd = 4'h0;
            if (q.cmd[CMD_START] || q.cmd[CMD_STOP]) begin
                d.stat[ST_CMDFIN] = 1'b1;
                if (!q.stat[ST_CMDFIN]) begin
                    d.ev_flag[EV_CMD] = 1'b1;
                end
            end
            if (q.cmd[CMD_SEND]) begin
                d.stat[ST_TXFIN] = 1'b1;
                d.stat[ST_RXNAK] = sda_i;
                if (!q.stat[ST_TXFIN]) begin
                    d.ev_flag[EV_TX] = 1'b1;
                end
                if (sda_i) begin
                    d.ev_flag[EV_NACK] = 1'b1;
                end
            end
            if (q.cmd[CMD_RECV]) begin
                d.stat[ST_RXFIN] = 1'b1;
                d.stat[ST_RXNAK] = sda_i;
                if (!q.stat[ST_RXFIN]) begin
                    d.ev_flag[EV_RX] = 1'b1;
                end
                // a read in this same cycle frees the buffer first
                if (q.rx_full && !rd_data) begin
                    d.ev_flag[EV_OVR] = 1'b1;
                end else begin
                    d.rx_buf = q.shift;
                    d.rx_full = 1'b1;
                end
            end
        end

        d.irq = q.top_en && |(q.ev_flag & q.ev_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.mode <= MODE_RST;
            q.lin <= RATE_LIN_RST;
            q.exp <= RATE_EXP_RST;
            q.scl_rel <= 1'b1;
            q.sda_rel <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign wb_dat_o = q.wb_dat;
    assign wb_ack_o = q.wb_ack;
    assign scl_o = q.pin_lo;
    assign sda_o = q.pin_lo;
    assign scl_oe_n_o = q.scl_rel;
    assign sda_oe_n_o = q.sda_rel;
    assign irq_o = q.irq;

    chk_mode_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && q.mode != MODE_I2C) |=> q.st == ST_IDLE
    ) else $error("engine left idle while not in bus mode");

    chk_start_seq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_START_C && half_tick)
            |=> (q.st == ST_IDLE && !q.sda_rel && !q.scl_rel && q.stat[ST_CMDFIN])
    ) else $error("start did not end with both lines low and done set");

    chk_send_bit: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_BIT_LO && q.cmd[CMD_SEND] && q.nbit < DATA_BITS && !q.sda_pend)
            |-> q.sda_rel == q.shift[7]
    ) else $error("sent data bit differs from shift register");

    chk_recv_ack: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_BIT_LO && q.cmd[CMD_RECV] && q.nbit == DATA_BITS && !q.sda_pend)
            |-> q.sda_rel == !q.ack_sel
    ) else $error("receive answer bit does not follow ack select");

    chk_stop_seq: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_STOP_B && half_tick && scl_i)
            |=> (q.sda_rel && q.scl_rel && q.cmd == 4'h0 && q.stat[ST_CMDFIN])
    ) else $error("stop did not release data with clock high");

    chk_idle_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (q.st == ST_IDLE && q.cmd == 4'h0) |=> q.st == ST_IDLE
    ) else $error("engine moved with no command pending");

    chk_cmd_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        seg_end |=> (q.cmd == 4'h0 && q.st == ST_IDLE && $past(q.cmd) != 4'h0)
    ) else $error("command bit not cleared at segment end");

    chk_tx_nack: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (seg_end && q.cmd[CMD_SEND] && sda_i) |=> (q.ev_flag[EV_NACK] && q.stat[ST_RXNAK])
    ) else $error("nack after send not flagged");

    chk_rx_overrun: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (seg_end && q.cmd[CMD_RECV] && q.rx_full && !rd_data)
            |=> (q.ev_flag[EV_OVR] && q.rx_buf == $past(q.rx_buf))
    ) else $error("overrun not flagged or held byte overwritten");

    chk_underrun: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (launch && q.cmd[CMD_SEND] && !q.tx_full) |=> q.ev_flag[EV_UND]
    ) else $error("send from empty buffer not flagged");

    chk_irq_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == ($past(q.top_en) && |($past(q.ev_flag) & $past(q.ev_mask)))
    ) else $error("interrupt output not gated by both masks");
endmodule : i2c_master_segment_engine

// ### tb/i2c_slave_model.sv
// behavioural two-wire slave with open-drain outputs and optional clock stretch
`timescale 1ns/1ns
module i2c_slave_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic stretch_i,
    input wire logic [7:0] rd_byte_i,
    output logic scl_oe_n_o,
    output logic sda_oe_n_o,
    output logic [7:0] got_o,
    output int starts_o,
    output int stops_o
);
    logic [7:0] sh = 8'h00;
    int bits = 0;
    logic act = 1'b0;
    logic adr_ph = 1'b0;
    logic rd = 1'b0;
    logic mack = 1'b0;
    initial begin
        scl_oe_n_o = 1'b1;
        sda_oe_n_o = 1'b1;
        got_o = 8'h00;
        starts_o = 0;
        stops_o = 0;
    end
    always @(negedge sda_i) if (scl_i) begin
        act = 1'b1;
        adr_ph = 1'b1;
        rd = 1'b0;
        bits = 0;
        starts_o++;
    end
    always @(posedge sda_i) if (scl_i && act) begin
        act = 1'b0;
        stops_o++;
    end
    always @(posedge scl_i) if (act) begin
        if (bits < 8) sh = {sh[6:0], sda_i};
        else mack = !sda_i;
        bits++;
    end
    // bus lines change only while the clock is low
    always @(negedge scl_i) if (act) begin
        if (bits == 8) begin
            if (adr_ph) begin
                rd = (sh[7:1] == DEV_ADDR) && sh[0];
                got_o = sh;
                sda_oe_n_o = (sh[7:1] != DEV_ADDR);
            end else begin
                got_o = sh;
                sda_oe_n_o = rd;
            end
        end else begin
            if (bits == 9) begin
                bits = 0;
                adr_ph = 1'b0;
                rd = rd && mack;
            end
            sda_oe_n_o = rd ? rd_byte_i[3'(7 - bits)] : 1'b1;
        end
    end
    always @(negedge scl_i) if (stretch_i) begin
        scl_oe_n_o = 1'b0;
        #120;
        scl_oe_n_o = 1'b1;
    end
endmodule : i2c_slave_model

// ### tb/i2c_master_segment_engine_tb.sv
// self-checking bench for the two-wire segment engine
`timescale 1ns/1ns
module i2c_master_segment_engine_tb;
    import i2c_seg_pkg::*;
    localparam logic [6:0] SLV = 7'h2a;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack, m_scl_o, m_sda_o, m_scl_oe_n, m_sda_oe_n, s_scl_oe_n, s_sda_oe_n, irq;
    logic stretch = 1'b0;
    logic [7:0] rd_byte = 8'h3c;
    logic [7:0] got;
    int starts, stops;
    int err_count = 0;
    int cmp_count = 0;
    // pull-ups on both lines
    wire scl = (m_scl_oe_n | m_scl_o) & s_scl_oe_n;
    wire sda = (m_sda_oe_n | m_sda_o) & s_sda_oe_n;
    always #2 clk_i = ~clk_i;
    i2c_master_segment_engine i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .scl_i(scl), .scl_o(m_scl_o),
        .scl_oe_n_o(m_scl_oe_n), .sda_i(sda), .sda_o(m_sda_o), .sda_oe_n_o(m_sda_oe_n),
        .irq_o(irq));
    i2c_slave_model #(.DEV_ADDR(SLV)) i_slave (.scl_i(scl), .sda_i(sda),
        .stretch_i(stretch), .rd_byte_i(rd_byte), .scl_oe_n_o(s_scl_oe_n),
        .sda_oe_n_o(s_sda_oe_n), .got_o(got), .starts_o(starts), .stops_o(stops));
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    task automatic timeout();
        err_count++;
        give_verdict();
    endtask : timeout
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 100) timeout();
    endtask : wbx
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wbx(1'b1, a, d, q);
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbx(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask : rdchk
    task automatic wait_done();
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h1;
        while (q[3:0] !== 4'h0 && n < 1000) begin
            wbx(1'b0, ADDR_CTRL1, 32'h0, q);
            n++;
        end
        if (n >= 1000) timeout();
    endtask : wait_done
    task automatic seg(input int b);
        wr(ADDR_CTRL1, 32'(1) << b);
        wait_done();
    endtask : seg
    task automatic period(output int per);
        int n, r, first;
        logic prev;
        n = 0;
        r = 0;
        first = 0;
        per = 0;
        prev = scl;
        // cycles between the first two rising bus clock edges
        while (r < 2 && n < 3000) begin
            @(posedge clk_i);
            n++;
            if (scl && !prev) begin
                r++;
                if (r == 1) begin
                    first = n;
                end else begin
                    per = n - first;
                end
            end
            prev = scl;
        end
        if (n >= 3000) timeout();
    endtask : period
    task automatic irqchk(input logic e);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irqchk
    task automatic t_reset();
        rdchk("mode", ADDR_MODE, 32'h0);
        rdchk("rate lin", ADDR_LIN, 32'(RATE_LIN_RST));
        rdchk("rate exp", ADDR_EXP, 32'(RATE_EXP_RST));
        rdchk("events", ADDR_EVFLAG, 32'h0);
        rdchk("top enable", ADDR_TOPEN, 32'h0);
        chk("pins low", 32'h0, {30'h0, m_scl_o, m_sda_o});
        rdchk("status", ADDR_STAT, 32'h0);
        wr(8'h3c, 32'hffffffff);
        rdchk("unmapped", 8'h3c, 32'h0);
        chk("lines idle", 32'h3, {30'h0, m_scl_oe_n, m_sda_oe_n});
        $display("test reset done");
    endtask : t_reset
    task automatic t_mode();
        wr(ADDR_CTRL1, 32'h1);
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_MODE, 32'(m));
            repeat (200) @(posedge clk_i);
            chk("no start", 32'h0, 32'(starts));
        end
        rdchk("cmd held", ADDR_CTRL1, 32'h1);
        wr(ADDR_MODE, 32'(MODE_I2C));
        wait_done();
        chk("start seen", 32'h1, 32'(starts));
        rdchk("status", ADDR_STAT, 32'(1 << ST_CMDFIN));
        rdchk("events", ADDR_EVFLAG, 32'(1 << EV_CMD));
        $display("test mode done");
    endtask : t_mode
    task automatic t_write();
        int per, lo;
        lo = 8 * CLK_MHZ / REF_MHZ - 3;
        wr(ADDR_EVFLAG, 32'h3f);
        wr(ADDR_LIN, 32'h1);
        wr(ADDR_EXP, 32'h1);
        wr(ADDR_DATA, {24'h0, SLV, 1'b0});
        fork
            seg(CMD_SEND);
            period(per);
        join
        chk("bit period", 32'h1, 32'(per >= lo && per <= lo + 12));
        chk("addr byte", {24'h0, SLV, 1'b0}, {24'h0, got});
        rdchk("status", ADDR_STAT, 32'(1 << ST_TXFIN));
        wr(ADDR_LIN, 32'h0);
        wr(ADDR_EXP, 32'h0);
        stretch <= 1'b1;
        wr(ADDR_DATA, 32'h96);
        seg(CMD_SEND);
        stretch <= 1'b0;
        chk("data byte", 32'h96, {24'h0, got});
        wr(ADDR_EVFLAG, 32'h3f);
        seg(CMD_SEND);
        rdchk("underrun", ADDR_EVFLAG, 32'((1 << EV_TX) | (1 << EV_UND)));
        seg(CMD_START);
        chk("restart", 32'h2, 32'(starts));
        wr(ADDR_DATA, {24'h0, SLV + 7'h1, 1'b0});
        seg(CMD_SEND);
        rdchk("nack", ADDR_STAT, 32'((1 << ST_TXFIN) | (1 << ST_RXNAK)));
        rdchk("nack ev", ADDR_EVFLAG, 32'h27);
        seg(CMD_STOP);
        chk("stop", 32'h1, 32'(stops));
        repeat (100) @(posedge clk_i);
        chk("idle", 32'h3, {30'h0, m_scl_oe_n, m_sda_oe_n});
        $display("test write done");
    endtask : t_write
    task automatic t_read();
        wr(ADDR_EVFLAG, 32'h3f);
        seg(CMD_START);
        wr(ADDR_DATA, {24'h0, SLV, 1'b1});
        seg(CMD_SEND);
        wr(ADDR_CTRL2, 32'h1);
        seg(CMD_RECV);
        rdchk("rx ack", ADDR_STAT, 32'(1 << ST_RXFIN));
        rd_byte <= 8'h43;
        seg(CMD_RECV);
        rdchk("overrun", ADDR_EVFLAG, 32'h1d);
        rdchk("kept byte", ADDR_DATA, 32'h3c);
        rd_byte <= 8'h5a;
        wr(ADDR_CTRL2, 32'h0);
        seg(CMD_RECV);
        rdchk("rx nack", ADDR_STAT, 32'((1 << ST_RXFIN) | (1 << ST_RXNAK)));
        rdchk("rx byte", ADDR_DATA, 32'h5a);
        seg(CMD_STOP);
        chk("stop", 32'h2, 32'(stops));
        $display("test read done");
    endtask : t_read
    task automatic t_irq();
        irqchk(1'b0);
        wr(ADDR_EVMASK, 32'(1 << EV_RX));
        irqchk(1'b0);
        wr(ADDR_TOPEN, 32'h1);
        irqchk(1'b1);
        wr(ADDR_EVFLAG, 32'(1 << EV_RX));
        irqchk(1'b0);
        wr(ADDR_EVMASK, 32'(1 << EV_OVR));
        irqchk(1'b1);
        $display("test irq done");
    endtask : t_irq
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_mode();
        t_write();
        t_read();
        t_irq();
        give_verdict();
    end
endmodule : i2c_master_segment_engine_tb
